// ### core/ssd_defs.vh
/*
 Constants of the serial stepper command decoder: word layout, codes, timing.
 Assumes inclusion by the scaler and decoder core files; holds definitions only.
*/
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH

// ****************************************
// Word layout
// ****************************************
`define SSD_WORD_BITS      32
`define SSD_CF_STALL       2
`define SSD_CF_FLOOR_LO    3
`define SSD_CF_RATE_LO     6
`define SSD_CF_BOOST_LO    8
`define SSD_CF_SENSE       12
`define SSD_CF_GAIN        13
`define SSD_CF_ZERO_MASK   32'hffffcc03
`define SSD_MC_TORQUE_LO   2
`define SSD_MC_A_DECAY_LO  6
`define SSD_MC_A_POL       8
`define SSD_MC_A_CODE_LO   9
`define SSD_MC_B_DECAY_LO  19
`define SSD_MC_B_POL       21
`define SSD_MC_B_CODE_LO   22
`define SSD_MC_ZERO_MASK   32'h00000023

// ****************************************
// Codes and reset values
// ****************************************
`define SSD_DECAY_375      2'h0
`define SSD_DECAY_50       2'h1
`define SSD_DECAY_FAST     2'h2
`define SSD_DECAY_ADAPT    2'h3
`define SSD_TQ_0           7'h64
`define SSD_TQ_1           7'h55
`define SSD_TQ_2           7'h46
`define SSD_TQ_3           7'h3c
`define SSD_TQ_4           7'h32
`define SSD_TQ_5           7'h28
`define SSD_TQ_6           7'h19
`define SSD_TQ_7           7'h0a
`define SSD_TQ_FULL        17'h00064
`define SSD_FLOOR_BASE     7'h2d
`define SSD_FLOOR_STEP     7'h05
`define SSD_BOOST_BASE     4'hb
`define SSD_RATE_STEP      10'h0e1
`define SSD_GAIN_LOW       4'h5
`define SSD_GAIN_HIGH      4'ha
`define SSD_RST_CODE       10'h000
`define SSD_RST_BYTE       8'h00

// ****************************************
// Timing
// ****************************************
`define SSD_MCLK_NS        8
`define SSD_OSC_NS         200
`define SSD_OSC_DIV        (`SSD_OSC_NS / `SSD_MCLK_NS)
`define SSD_CHOP_CLKS      16
`define SSD_FAST_375_CLKS  4'h6
`define SSD_FAST_50_CLKS   4'h8

`endif

// ### core/ssd_sync.v
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the pins are unrelated to mclk; each bit is synchronised alone.
*/
`timescale 1ns/1ns
`default_nettype none
module ssd_sync #(
	parameter WIDTH = 1
)(
	input  wire             mclk,
	input  wire             srst,
	input  wire [WIDTH-1:0] pinIn,
	output reg  [WIDTH-1:0] synced
);
	reg [WIDTH-1:0] meta;

	always @(posedge mclk)
	begin
		if (srst)
		begin
			meta <= {WIDTH{1'b0}};
			synced <= {WIDTH{1'b0}};
		end
		else
		begin
			meta <= pinIn;
			synced <= meta;
		end
	end
endmodule
`default_nettype wire

// ### core/ssd_scale.v
/*
 Torque scaling of one phase current code into a DAC level.
 Assumes code and torque are steady register values on mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defs.vh"
module ssd_scale (
	input  wire       mclk,
	input  wire       srst,
	input  wire [9:0] code,
	input  wire [2:0] torque,
	output reg  [9:0] level
);
	reg  [6:0]  pct;
	wire [16:0] prod;
	wire [16:0] quot;

	// Torque percentage
	always @*
	begin
		case (torque)
			3'h0: pct = `SSD_TQ_0;
			3'h1: pct = `SSD_TQ_1;
			3'h2: pct = `SSD_TQ_2;
			3'h3: pct = `SSD_TQ_3;
			3'h4: pct = `SSD_TQ_4;
			3'h5: pct = `SSD_TQ_5;
			3'h6: pct = `SSD_TQ_6;
			default: pct = `SSD_TQ_7;
		endcase
	end

	// Level is code times torque share, full scale 1023
	assign prod = {7'h00, code} * {10'h000, pct};
	assign quot = prod / `SSD_TQ_FULL;

	always @(posedge mclk)
	begin
		if (srst)
			level <= `SSD_RST_CODE;
		else
			level <= quot[9:0];
	end
endmodule
`default_nettype wire

// ### core/ssd_decoder.v
/*
 Serial command decoder and per-phase chopper of a two-phase stepper driver.
 Assumes serial pins are asynchronous to mclk, and that the threshold
 comparators deliver one level per phase, high while current is at threshold.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ssd_defs.vh"
module ssd_decoder #(
	parameter OSC_DIV = `SSD_OSC_DIV
)(
	input  wire        mclk,
	input  wire        srst,
	input  wire        interfaceSelect,
	input  wire        bankSelect,
	input  wire        serialClock,
	input  wire        serialData,
	input  wire        latchStrobe,
	input  wire [1:0]  currentThresholdHit,
	output reg         antiStallEnable,
	output reg  [2:0]  bottomCurrentLimitCode,
	output reg  [1:0]  frequencyLimitCode,
	output reg  [1:0]  boostCode,
	output reg  [6:0]  bottomLimitPercent,
	output reg  [3:0]  boostSteps,
	output reg  [9:0]  frequencyLimitHz,
	output reg         senseModeSelect,
	output reg         resistorlessSensing,
	output reg         referenceGainSelect,
	output reg  [3:0]  referenceGainDivisor,
	output reg  [2:0]  torqueScale,
	output reg  [1:0]  phasePolarity,
	output reg  [3:0]  phaseDecaySelect,
	output wire [9:0]  phaseALevel,
	output wire [9:0]  phaseBLevel,
	output wire [1:0]  phaseCharge,
	output wire [1:0]  phaseFastDecay,
	output wire [1:0]  phaseSlowDecay,
	output reg         stepPulse,
	output reg  [15:0] stepCount,
	output reg         formatError,
	output reg         outputsOn
);
	// ****************************************
	// Chopper states
	// ****************************************
	localparam ST_OFF    = 2'h0;
	localparam ST_CHARGE = 2'h1;
	localparam ST_FAST   = 2'h2;
	localparam ST_SLOW   = 2'h3;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	wire [6:0] pinSync;
	reg        clkPrev;
	reg        latchPrev;
	wire       ifOn;
	wire       bankHigh;
	wire       sdata;
	wire       clkRise;
	wire       latchRise;
	wire [1:0] hit;

	ssd_sync #(
		.WIDTH (7)
	) uPins (
		.mclk   (mclk),
		.srst   (srst),
		.pinIn  ({currentThresholdHit, latchStrobe, serialClock, serialData,
			bankSelect, interfaceSelect}),
		.synced (pinSync)
	);

	assign ifOn = pinSync[0];
	assign bankHigh = pinSync[1];
	assign sdata = pinSync[2];
	assign clkRise = pinSync[3] & ~clkPrev;
	assign latchRise = pinSync[4] & ~latchPrev;
	assign hit = pinSync[6:5];

	always @(posedge mclk)
	begin
		if (srst)
		begin
			clkPrev <= 1'b0;
			latchPrev <= 1'b0;
		end
		else
		begin
			clkPrev <= pinSync[3];
			latchPrev <= pinSync[4];
		end
	end

	// ****************************************
	// Word shifter
	// ****************************************
	reg  [31:0] shiftWord;
	reg  [4:0]  bitCount;
	wire [31:0] next_word;
	wire        wordDone;

	// D0 arrives first and ends in bit 0
	assign next_word = {sdata, shiftWord[31:1]};
	assign wordDone = ifOn & clkRise & (bitCount == 5'h1f);

	always @(posedge mclk)
	begin
		if (srst || !ifOn)
		begin
			shiftWord <= 32'h00000000;
			bitCount <= 5'h00;
		end
		else if (latchRise)
			bitCount <= 5'h00;
		else if (clkRise)
		begin
			shiftWord <= next_word;
			bitCount <= bitCount + 5'h01;
		end
	end

	// ****************************************
	// Word decode
	// ****************************************
	wire cfgWord;
	wire motorWord;
	wire cfgBad;
	wire motorBad;

	assign cfgWord = wordDone & ~bankHigh;
	assign motorWord = wordDone & bankHigh;
	assign cfgBad = |(next_word & `SSD_MC_ZERO_MASK & 32'h0) |
		|(next_word & `SSD_CF_ZERO_MASK);
	assign motorBad = |(next_word & `SSD_MC_ZERO_MASK);

	// Configuration and its decoded values
	always @(posedge mclk)
	begin
		if (srst)
		begin
			antiStallEnable <= 1'b0;
			bottomCurrentLimitCode <= 3'h0;
			frequencyLimitCode <= 2'h0;
			boostCode <= 2'h0;
			bottomLimitPercent <= `SSD_FLOOR_BASE;
			boostSteps <= `SSD_BOOST_BASE;
			frequencyLimitHz <= 10'h000;
			senseModeSelect <= 1'b0;
			resistorlessSensing <= 1'b1;
			referenceGainSelect <= 1'b0;
			referenceGainDivisor <= `SSD_GAIN_LOW;
		end
		else if (cfgWord && !cfgBad)
		begin
			antiStallEnable <= next_word[`SSD_CF_STALL];
			bottomCurrentLimitCode <= next_word[`SSD_CF_FLOOR_LO +: 3];
			frequencyLimitCode <= next_word[`SSD_CF_RATE_LO +: 2];
			boostCode <= next_word[`SSD_CF_BOOST_LO +: 2];
			bottomLimitPercent <= `SSD_FLOOR_BASE +
				`SSD_FLOOR_STEP * {4'h0, next_word[`SSD_CF_FLOOR_LO +: 3]};
			boostSteps <= `SSD_BOOST_BASE -
				{1'b0, next_word[`SSD_CF_BOOST_LO +: 2], 1'b0};
			frequencyLimitHz <= `SSD_RATE_STEP *
				{8'h00, next_word[`SSD_CF_RATE_LO +: 2]};
			senseModeSelect <= next_word[`SSD_CF_SENSE];
			resistorlessSensing <= ~next_word[`SSD_CF_SENSE];
			referenceGainSelect <= next_word[`SSD_CF_GAIN];
			referenceGainDivisor <= next_word[`SSD_CF_GAIN] ?
				`SSD_GAIN_HIGH : `SSD_GAIN_LOW;
		end
	end

	// ****************************************
	// Pending and applied motor settings
	// ****************************************
	reg [2:0]  pendTorque;
	reg [3:0]  pendDecay;
	reg [1:0]  pendPol;
	reg [19:0] pendCode;
	reg        pendValid;
	reg [19:0] appliedCode;
	wire       applyNow;

	assign applyNow = latchRise & pendValid & ifOn;

	always @(posedge mclk)
	begin
		if (srst)
		begin
			pendTorque <= 3'h0;
			pendDecay <= 4'h0;
			pendPol <= 2'h0;
			pendCode <= {`SSD_RST_CODE, `SSD_RST_CODE};
			pendValid <= 1'b0;
		end
		else if (motorWord && !motorBad)
		begin
			pendTorque <= next_word[`SSD_MC_TORQUE_LO +: 3];
			pendDecay <= {next_word[`SSD_MC_B_DECAY_LO +: 2],
				next_word[`SSD_MC_A_DECAY_LO +: 2]};
			pendPol <= {next_word[`SSD_MC_B_POL], next_word[`SSD_MC_A_POL]};
			pendCode <= {next_word[`SSD_MC_B_CODE_LO +: 10],
				next_word[`SSD_MC_A_CODE_LO +: 10]};
			pendValid <= 1'b1;
		end
		else if (applyNow)
			pendValid <= 1'b0;
	end

	always @(posedge mclk)
	begin
		if (srst)
		begin
			torqueScale <= 3'h0;
			phaseDecaySelect <= 4'h0;
			phasePolarity <= 2'h0;
			appliedCode <= {`SSD_RST_CODE, `SSD_RST_CODE};
			stepPulse <= 1'b0;
			stepCount <= 16'h0000;
			outputsOn <= 1'b0;
		end
		else
		begin
			stepPulse <= applyNow;
			if (applyNow)
			begin
				torqueScale <= pendTorque;
				phaseDecaySelect <= pendDecay;
				phasePolarity <= pendPol;
				appliedCode <= pendCode;
				stepCount <= stepCount + 16'h0001;
				outputsOn <= 1'b1;
			end
			else if (cfgWord || !ifOn)
				outputsOn <= 1'b0;
		end
	end

	// Word format check
	always @(posedge mclk)
	begin
		if (srst)
			formatError <= 1'b0;
		else if (cfgWord)
			formatError <= cfgBad;
		else if (motorWord)
			formatError <= motorBad;
	end

	// ****************************************
	// Torque scaling
	// ****************************************
	ssd_scale uScaleA (
		.mclk   (mclk),
		.srst   (srst),
		.code   (appliedCode[9:0]),
		.torque (torqueScale),
		.level  (phaseALevel)
	);

	ssd_scale uScaleB (
		.mclk   (mclk),
		.srst   (srst),
		.code   (appliedCode[19:10]),
		.torque (torqueScale),
		.level  (phaseBLevel)
	);

	// ****************************************
	// Oscillator and chopping cycle
	// ****************************************
	reg [7:0] oscCount;
	reg       oscTick;
	reg [3:0] cycCount;
	wire      cycEnd;

	assign cycEnd = oscTick & (cycCount == 4'hf);

	always @(posedge mclk)
	begin
		if (srst)
		begin
			oscCount <= 8'h00;
			oscTick <= 1'b0;
			cycCount <= 4'h0;
		end
		else
		begin
			oscTick <= (oscCount == OSC_DIV[7:0] - 8'h01);
			if (oscCount == OSC_DIV[7:0] - 8'h01)
				oscCount <= 8'h00;
			else
				oscCount <= oscCount + 8'h01;
			if (oscTick)
				cycCount <= cycCount + 4'h1;
		end
	end

	// ****************************************
	// Per-phase chopper
	// ****************************************
	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1)
		begin : gPhase
			reg  [1:0] state;
			reg  [1:0] next_state;
			reg  [3:0] fastCount;
			reg  [3:0] next_fast;
			reg        downStep;
			reg        next_down;
			reg        chg;
			reg        fst;
			reg        slw;
			wire [1:0] mode;
			wire [3:0] fastLimit;

			assign mode = phaseDecaySelect[2*p +: 2];
			assign fastLimit = (mode == `SSD_DECAY_375) ?
				`SSD_FAST_375_CLKS : `SSD_FAST_50_CLKS;

			always @*
			begin
				next_state = state;
				next_fast = fastCount;
				next_down = downStep;
				case (state)
					ST_OFF:
						next_state = ST_CHARGE;
					ST_CHARGE:
						// Charge runs past the cycle end until threshold
						if (hit[p])
						begin
							next_state = ST_FAST;
							next_fast = 4'h0;
						end
					ST_FAST:
						if (mode == `SSD_DECAY_ADAPT)
						begin
							// Decay current watched too
							if (!hit[p])
							begin
								next_state = ST_SLOW;
								next_down = 1'b0;
							end
							else if (cycEnd && !downStep)
								next_state = ST_CHARGE;
						end
						else if (cycEnd)
							next_state = ST_CHARGE;
						else if (oscTick && mode != `SSD_DECAY_FAST)
						begin
							if (fastCount == fastLimit - 4'h1)
								next_state = ST_SLOW;
							else
								next_fast = fastCount + 4'h1;
						end
					ST_SLOW:
						if (cycEnd)
							next_state = ST_CHARGE;
					default:
						next_state = ST_OFF;
				endcase
				if (applyNow && pendCode[10*p +: 10] < appliedCode[10*p +: 10])
					next_down = 1'b1;
				if (!outputsOn)
				begin
					next_state = ST_OFF;
					next_down = 1'b0;
				end
			end

			always @(posedge mclk)
			begin
				if (srst)
				begin
					state <= ST_OFF;
					fastCount <= 4'h0;
					downStep <= 1'b0;
					chg <= 1'b0;
					fst <= 1'b0;
					slw <= 1'b0;
				end
				else
				begin
					state <= next_state;
					fastCount <= next_fast;
					downStep <= next_down;
					chg <= (next_state == ST_CHARGE);
					fst <= (next_state == ST_FAST);
					slw <= (next_state == ST_SLOW);
				end
			end

			assign phaseCharge[p] = chg;
			assign phaseFastDecay[p] = fst;
			assign phaseSlowDecay[p] = slw;
		end
	endgenerate
endmodule
`default_nettype wire

// ### core/ssd_decoder_unused_placeholder.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ### bench/ssd_decoder_asserts.sv
/*
 Concurrent checks on the decoder ports.
 Assumes one mclk domain and a bind to every ssd_decoder.
*/
`timescale 1ns/1ns
`default_nettype none
module ssd_decoder_asserts #(
	parameter OSC_DIV = 25
)(
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        latchStrobe,
	input wire logic [1:0]  currentThresholdHit,
	input wire logic        senseModeSelect,
	input wire logic        resistorlessSensing,
	input wire logic        referenceGainSelect,
	input wire logic [3:0]  referenceGainDivisor,
	input wire logic [2:0]  bottomCurrentLimitCode,
	input wire logic [6:0]  bottomLimitPercent,
	input wire logic [3:0]  phaseDecaySelect,
	input wire logic [1:0]  phaseCharge,
	input wire logic [1:0]  phaseFastDecay,
	input wire logic [1:0]  phaseSlowDecay,
	input wire logic        stepPulse,
	input wire logic [15:0] stepCount,
	input wire logic        outputsOn
);
	logic [2:0] latchAge;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// ****************************************
	// Cycles since latch strobe
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (srst || latchStrobe)
			latchAge <= 3'h0;
		else if (latchAge != 3'h7)
			latchAge <= latchAge + 3'h1;
	end
	sequence chargeLowA;
		(phaseCharge[0] && outputsOn && !currentThresholdHit[0]) [*4];
	endsequence
	sequence fastHighA;
		(phaseFastDecay[0] && currentThresholdHit[0] && phaseDecaySelect[1:0] == 2'h3) [*4];
	endsequence
	a_sense_invert: assert property (
		$stable(senseModeSelect) |-> resistorlessSensing == !senseModeSelect)
		else $error("sense flag wrong");
	a_gain_divisor: assert property (
		$stable(referenceGainSelect) |-> referenceGainDivisor == (referenceGainSelect ? 4'ha : 4'h5))
		else $error("gain divisor wrong");
	a_floor_percent: assert property (
		$stable(bottomCurrentLimitCode) |->
		bottomLimitPercent == 7'h2d + 7'h05 * {4'h0, bottomCurrentLimitCode})
		else $error("floor percent wrong");
	a_step_count: assert property (
		!$past(srst) |-> stepCount == $past(stepCount) + {15'h0000, stepPulse})
		else $error("step count not one per pulse");
	a_pulse_single: assert property (stepPulse |=> !stepPulse)
		else $error("step pulse too long");
	a_pulse_latch: assert property (stepPulse |-> latchAge <= 3'h5)
		else $error("step without latch");
	a_chop_onehot: assert property (
		$onehot0({phaseCharge[0], phaseFastDecay[0], phaseSlowDecay[0]}) &&
		$onehot0({phaseCharge[1], phaseFastDecay[1], phaseSlowDecay[1]}))
		else $error("chopper state not one-hot");
	a_chop_off: assert property (
		!outputsOn [*2] |-> (phaseCharge | phaseFastDecay | phaseSlowDecay) == 2'h0)
		else $error("chopper active while off");
	a_charge_holds: assert property (chargeLowA |=> phaseCharge[0] || !outputsOn)
		else $error("charge ended below threshold");
	a_fast_only: assert property (
		phaseFastDecay[0] && phaseDecaySelect[1:0] == 2'h2 |=>
		!phaseSlowDecay[0] || !$stable(phaseDecaySelect))
		else $error("slow decay in fast-only mode");
	a_fast_stays: assert property (
		fastHighA |=> !phaseSlowDecay[0] || !$stable(phaseDecaySelect))
		else $error("fast decay left above threshold");
endmodule
bind ssd_decoder ssd_decoder_asserts #(.OSC_DIV(OSC_DIV)) i_asserts (
	.mclk, .srst, .latchStrobe, .currentThresholdHit, .senseModeSelect,
	.resistorlessSensing, .referenceGainSelect, .referenceGainDivisor,
	.bottomCurrentLimitCode, .bottomLimitPercent, .phaseDecaySelect, .phaseCharge,
	.phaseFastDecay, .phaseSlowDecay, .stepPulse, .stepCount, .outputsOn
);
`default_nettype wire

// ### bench/ssd_host_model.sv
/*
 Host model that shifts 32-bit command words and strobes the latch.
 Assumes one task call at a time; pins change just after rising mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ssd_host_model (
	input  wire logic mclk,
	output var logic  bankSelect,
	output var logic  serialClock,
	output var logic  serialData,
	output var logic  latchStrobe
);
	// ****************************************
	// Idle levels and transfers
	// ****************************************
	initial
	begin
		bankSelect = 1'b0;
		serialClock = 1'b0;
		serialData = 1'b0;
		latchStrobe = 1'b0;
	end
	task automatic sendWord(input logic [31:0] word, input logic bank);
		@(posedge mclk);
		bankSelect <= bank;
		for (int b = 0; b < 32; b++)
		begin
			serialData <= word[b];
			repeat (4) @(posedge mclk);
			serialClock <= 1'b1;
			repeat (4) @(posedge mclk);
			serialClock <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		serialData <= ~word[31];
		@(negedge mclk);
	endtask
	task automatic latchPulse();
		@(posedge mclk);
		latchStrobe <= 1'b1;
		repeat (4) @(posedge mclk);
		latchStrobe <= 1'b0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
	endtask
endmodule
`default_nettype wire

// ### bench/test_ssd_decoder.sv
/*
 Self-checking bench of the serial stepper command decoder.
 Assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/1ns
`default_nettype none
`define SSD_CHK(what, exp, got) \
	begin \
		nTests++; \
		if ((got) !== (exp)) \
		begin \
			failCount++; \
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module test_ssd_decoder;
	typedef struct packed {logic [2:0] tq; logic [9:0] ca, cb, ea, eb;} ssdRow;
	ssdRow       rows [8] = '{'{3'h0, 10'h3ff, 10'h200, 10'h3ff, 10'h200},
		'{3'h1, 10'h3ff, 10'h200, 10'h365, 10'h1b3}, '{3'h2, 10'h3ff, 10'h200, 10'h2cc, 10'h166},
		'{3'h3, 10'h3ff, 10'h200, 10'h265, 10'h133}, '{3'h4, 10'h3ff, 10'h200, 10'h1ff, 10'h100},
		'{3'h5, 10'h3ff, 10'h200, 10'h199, 10'h0cc}, '{3'h6, 10'h3ff, 10'h200, 10'h0ff, 10'h080},
		'{3'h7, 10'h3ff, 10'h000, 10'h066, 10'h000}};
	logic        mclk, srst, interfaceSelect;
	logic [1:0]  currentThresholdHit;
	logic [31:0] w;
	int          failCount, nTests, cycles, i, misses;
	wire logic   bankSelect, serialClock, serialData, latchStrobe, stepPulse, formatError;
	wire logic   antiStallEnable, senseModeSelect, resistorlessSensing, referenceGainSelect;
	wire logic   outputsOn;
	wire logic [1:0]  frequencyLimitCode, boostCode, phasePolarity;
	wire logic [1:0]  phaseCharge, phaseFastDecay, phaseSlowDecay;
	wire logic [2:0]  bottomCurrentLimitCode, torqueScale;
	wire logic [3:0]  boostSteps, referenceGainDivisor, phaseDecaySelect;
	wire logic [6:0]  bottomLimitPercent;
	wire logic [9:0]  frequencyLimitHz, phaseALevel, phaseBLevel;
	wire logic [15:0] stepCount;
	ssd_host_model host (.mclk, .bankSelect, .serialClock, .serialData, .latchStrobe);
	ssd_decoder #(.OSC_DIV(4)) i_dut (.mclk, .srst, .interfaceSelect, .bankSelect,
		.serialClock, .serialData, .latchStrobe, .currentThresholdHit, .antiStallEnable,
		.bottomCurrentLimitCode, .frequencyLimitCode, .boostCode, .bottomLimitPercent,
		.boostSteps, .frequencyLimitHz, .senseModeSelect, .resistorlessSensing,
		.referenceGainSelect, .referenceGainDivisor, .torqueScale, .phasePolarity,
		.phaseDecaySelect, .phaseALevel, .phaseBLevel, .phaseCharge, .phaseFastDecay,
		.phaseSlowDecay, .stepPulse, .stepCount, .formatError, .outputsOn);
	// ****************************************
	// Clock, timeout and closing report
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failCount++;
			giveVerdict();
		end
	end
	task automatic giveVerdict();
		$display("Checks %0d, mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic drive(input logic [1:0] hit, input logic sel);
		@(posedge mclk);
		currentThresholdHit <= hit;
		interfaceSelect <= sel;
	endtask
	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		srst = 1'b1;
		interfaceSelect = 1'b1;
		currentThresholdHit = 2'h0;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		repeat (4) @(negedge mclk);
		`SSD_CHK("rst", {7'h2d, 4'hb}, {bottomLimitPercent, boostSteps})
		`SSD_CHK("rstgain", 4'h5, referenceGainDivisor)
		`SSD_CHK("rst2", {1'b1, 17'h00000}, {resistorlessSensing, stepCount, outputsOn})
		for (i = 0; i < 4; i++)
		begin
			w = {18'h00000, i[1], i[0], 2'h0, i[1:0], i[1:0], 3'(2 * i + 1), i[0], 2'h0};
			host.sendWord(w, 1'b0);
			repeat (2) @(negedge mclk);
			`SSD_CHK("cfgA", w[13:12], {referenceGainSelect, senseModeSelect})
			`SSD_CHK("cfgB", w[9:2], {boostCode, frequencyLimitCode, bottomCurrentLimitCode,
				antiStallEnable})
			`SSD_CHK("floor", 7'h32 + 7'h0a * 7'(i), bottomLimitPercent)
			`SSD_CHK("boost", 4'hb - 4'h2 * 4'(i), boostSteps)
			`SSD_CHK("rate", 10'h0e1 * 10'(i), frequencyLimitHz)
			`SSD_CHK("sense", ~i[0], resistorlessSensing)
			`SSD_CHK("gain", i[1] ? 4'ha : 4'h5, referenceGainDivisor)
		end
		host.sendWord(32'h00000400, 1'b0);
		`SSD_CHK("badcfg", 2'h3, {formatError, antiStallEnable})
		drive(2'h3, 1'b1);
		for (i = 0; i < 8; i++)
		begin
			w = {rows[i].cb, ~i[0], ~i[1:0], rows[i].ca, i[0], i[1:0], 1'b0, rows[i].tq, 2'h0};
			host.sendWord(w, 1'b1);
			`SSD_CHK("held", 16'(i), stepCount)
			host.latchPulse();
			`SSD_CHK("step", 16'(i + 1), stepCount)
			`SSD_CHK("torque", rows[i].tq, torqueScale)
			`SSD_CHK("pol", {~i[0], i[0]}, phasePolarity)
			`SSD_CHK("decay", {~i[1:0], i[1:0]}, phaseDecaySelect)
			`SSD_CHK("level", {rows[i].ea, rows[i].eb}, {phaseALevel, phaseBLevel})
		end
		`SSD_CHK("on", 2'h2, {outputsOn, formatError})
		host.sendWord(32'h00000020, 1'b1);
		host.latchPulse();
		`SSD_CHK("badmot", {1'b1, 16'h0008}, {formatError, stepCount})
		drive(2'h3, 1'b0);
		host.sendWord(w, 1'b1);
		host.latchPulse();
		`SSD_CHK("off", {1'b0, 16'h0008}, {outputsOn, stepCount})
		drive(2'h0, 1'b1);
		host.sendWord(32'h0007ffc0, 1'b1);
		host.latchPulse();
		repeat (200) @(negedge mclk);
		`SSD_CHK("charge", 1'b1, phaseCharge[0])
		drive(2'h3, 1'b1);
		repeat (10) @(negedge mclk);
		`SSD_CHK("fast", 1'b1, phaseFastDecay[0])
		host.sendWord(32'h0000c9c0, 1'b1);
		host.latchPulse();
		repeat (130) @(negedge mclk);
		// Watch a whole chopping cycle: fast decay must span its end
		misses = 0;
		for (i = 0; i < 70; i++)
		begin
			@(negedge mclk);
			if (phaseFastDecay[0] !== 1'b1)
				misses++;
		end
		`SSD_CHK("down", 32'h00000000, misses)
		drive(2'h0, 1'b1);
		for (i = 0; i < 10 && phaseFastDecay[0] === 1'b1; i++)
			@(negedge mclk);
		`SSD_CHK("slow", 1'b1, phaseSlowDecay[0])
		giveVerdict();
	end
endmodule
`default_nettype wire
